//--- hdl/pms_pkg.sv
package pms_pkg;
	localparam logic [7:0] PMS_OFFSET = 8'h0f;
	localparam logic [7:0] PMS_RESET = 8'h00;
	localparam int PMS_ALERT_BIT = 5;
	localparam int PMS_ATTACH_BIT = 4;
	localparam int PMS_CHG_BIT = 3;
	localparam int PMS_EM_BIT = 2;
	localparam int PMS_STEP_LSB = 0;
	localparam int PMS_CUR_W = 8;
	localparam logic [1:0] PMS_STEP_NONE = 2'h0;
endpackage

//--- hdl/pms_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pms_sync_if;
	logic alert_n;
	logic attach_n;
	logic alert_low;
	logic attach_low;
	modport src (output alert_n, output attach_n,
		input alert_low, input attach_low);
	modport dst (input alert_n, input attach_n,
		output alert_low, output attach_low);
endinterface
`default_nettype wire

//--- hdl/pms_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three stages; a level is accepted once stages two and three agree
module pms_pin_sync (
	input wire logic clk,
	input wire logic rst,
	pms_sync_if.dst sif
);
	logic [2:0] al_r;
	logic [2:0] at_r;
	logic al_low_r;
	logic at_low_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			al_r <= 3'h7;
			at_r <= 3'h7;
			al_low_r <= 1'b0;
			at_low_r <= 1'b0;
		end else begin
			al_r <= {al_r[1:0], sif.alert_n};
			at_r <= {at_r[1:0], sif.attach_n};
			if (al_r[1] == al_r[2])
				al_low_r <= ~al_r[2];
			if (at_r[1] == at_r[2])
				at_low_r <= ~at_r[2];
		end
	end
	assign sif.alert_low = al_low_r;
	assign sif.attach_low = at_low_r;
endmodule
`default_nettype wire

//--- hdl/pms_status.sv
`timescale 1ns/1ps
`default_nettype none
module pms_status (
	input wire logic CLK,
	input wire logic RST,
	input wire logic ALERT_OUT_N,
	input wire logic ATTACH_OUT_N,
	input wire logic [7:0] BUS_CURRENT,
	input wire logic [7:0] CHARGING_CURRENT_THRESHOLD,
	input wire logic ACTIVE_STATE,
	input wire logic EMULATING,
	input wire logic [1:0] EMULATION_PAIR_INDEX,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic REG_WR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic [7:0] PORT_MISC_STATUS
);
	pms_sync_if sif ();
	assign sif.alert_n = ALERT_OUT_N;
	assign sif.attach_n = ATTACH_OUT_N;
	pms_pin_sync u_sync (
		.clk(CLK),
		.rst(RST),
		.sif(sif)
	);

	logic charging_current_flag_r;
	logic emulation_running_flag_r;
	logic [1:0] emulation_pair_index_r;
	logic [7:0] rdata_r;
	wire logic chg_above = BUS_CURRENT > CHARGING_CURRENT_THRESHOLD;
	wire logic chg_below = BUS_CURRENT < CHARGING_CURRENT_THRESHOLD;
	wire logic em_nxt = ACTIVE_STATE & EMULATING;
	wire logic [1:0] step_nxt = em_nxt ? EMULATION_PAIR_INDEX :
		pms_pkg::PMS_STEP_NONE;
	wire logic sel = REG_ADDR == pms_pkg::PMS_OFFSET;
	wire logic [7:0] status;
	assign status = {2'h0,
		sif.alert_low,
		sif.attach_low,
		charging_current_flag_r,
		emulation_running_flag_r,
		emulation_pair_index_r};

	// Equal current holds the flag, giving hysteresis at the threshold
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			charging_current_flag_r <= 1'b0;
			emulation_running_flag_r <= 1'b0;
			emulation_pair_index_r <= pms_pkg::PMS_STEP_NONE;
			rdata_r <= pms_pkg::PMS_RESET;
		end else begin
			if (chg_above)
				charging_current_flag_r <= 1'b1;
			else if (chg_below)
				charging_current_flag_r <= 1'b0;
			emulation_running_flag_r <= em_nxt;
			emulation_pair_index_r <= step_nxt;
			// Writes are ignored; there is no write path at all
			if (REG_RD)
				rdata_r <= sel ? status : 8'h00;
		end
	end
	assign REG_RDATA = rdata_r;
	assign PORT_MISC_STATUS = status;

	// Pin edge, then three steady samples before the flag may move
	sequence pin_fell_seq(sig);
		$fell(sig) ##1 !sig [*3];
	endsequence
	sequence pin_rose_seq(sig);
		$rose(sig) ##1 sig [*3];
	endsequence

	AST_TOP_ZERO: assert property (
		@(posedge CLK) disable iff (RST)
		REG_RD |=> REG_RDATA[7:6] == 2'h0)
		else $error("top bits nonzero");
	AST_ALERT: assert property (
		@(posedge CLK) disable iff (RST)
		pin_fell_seq(ALERT_OUT_N) |=> PORT_MISC_STATUS[5])
		else $error("alert bit not set");
	AST_ATTACH: assert property (
		@(posedge CLK) disable iff (RST)
		pin_rose_seq(ATTACH_OUT_N) |=> !PORT_MISC_STATUS[4])
		else $error("attach bit not cleared");
	AST_ATTACH_SET: assert property (
		@(posedge CLK) disable iff (RST)
		pin_fell_seq(ATTACH_OUT_N) |=> PORT_MISC_STATUS[4])
		else $error("attach bit not set");
	AST_CHG: assert property (
		@(posedge CLK) disable iff (RST)
		chg_above |=> PORT_MISC_STATUS[3])
		else $error("charging flag missed");
	AST_EM: assert property (
		@(posedge CLK) disable iff (RST)
		!ACTIVE_STATE |=> !PORT_MISC_STATUS[2])
		else $error("emulation flag while idle");
	AST_STEP: assert property (
		@(posedge CLK) disable iff (RST)
		em_nxt |=> PORT_MISC_STATUS[1:0] == $past(EMULATION_PAIR_INDEX))
		else $error("pair index stale");
	AST_WRITE: assert property (
		@(posedge CLK) disable iff (RST)
		REG_WR && sel && !REG_RD |=> $stable(REG_RDATA))
		else $error("write changed register");
endmodule
`default_nettype wire

//--- tb/pms_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module pms_status_test;
	logic clk = 0, rst = 1, al_n = 1, at_n = 1, act = 0, emu = 0;
	logic rd = 0, wr = 0;
	logic [7:0] cur = 8'h00, thr = 8'h40, addr = 8'h00, wd = 8'h00;
	logic [7:0] rdata, st;
	logic [1:0] idx = 2'h0;
	int bad_count = 0, n_compared = 0, cyc = 0;
	pms_status dut_u (.CLK(clk), .RST(rst), .ALERT_OUT_N(al_n),
		.ATTACH_OUT_N(at_n), .BUS_CURRENT(cur),
		.CHARGING_CURRENT_THRESHOLD(thr), .ACTIVE_STATE(act),
		.EMULATING(emu), .EMULATION_PAIR_INDEX(idx), .REG_ADDR(addr),
		.REG_RD(rd), .REG_WR(wr), .REG_WDATA(wd), .REG_RDATA(rdata),
		.PORT_MISC_STATUS(st));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Ceiling far above the roughly 64 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		addr = a;
		rd = 1;
		step(1);
		rd = 0;
		d = rdata;
	endtask
	// Settle n cycles first; the pin checks pass six for the synchroniser delay
	task automatic expect_st(input int n, input logic [7:0] e);
		logic [7:0] d;
		step(n);
		check(st, e);
		rd_reg(8'h0f, d);
		check(d, e);
	endtask
	task automatic pins_t;
		al_n = 0;
		expect_st(6, 8'h20);
		at_n = 0;
		expect_st(6, 8'h30);
		al_n = 1;
		at_n = 1;
		expect_st(6, 8'h00);
	endtask
	task automatic cur_t;
		cur = 8'h41;
		expect_st(2, 8'h08);
		cur = 8'h40;
		expect_st(2, 8'h08);
		cur = 8'h3f;
		expect_st(2, 8'h00);
	endtask
	task automatic emu_t;
		act = 1;
		idx = 2'h2;
		expect_st(2, 8'h00);
		emu = 1;
		for (int i = 0; i < 4; i++) begin
			idx = i[1:0];
			expect_st(2, {6'h01, i[1:0]});
		end
		act = 0;
		expect_st(2, 8'h00);
		emu = 0;
	endtask
	task automatic wr_t;
		logic [7:0] d;
		al_n = 0;
		cur = 8'hff;
		step(6);
		addr = 8'h0f;
		wd = 8'hff;
		wr = 1;
		step(1);
		wr = 0;
		expect_st(1, 8'h28);
		rd_reg(8'h10, d);
		check(d, 8'h00);
		check(st & 8'hc0, 8'h00);
	endtask
	task automatic print_verdict;
		$display("compared=%0d bad=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		step(6);
		rst = 0;
		check(st, 8'h00);
		pins_t();
		cur_t();
		emu_t();
		wr_t();
		print_verdict();
	end
endmodule
`default_nettype wire
